// ---- logic/aop_regs.svh ----
// register offsets, field positions, reset values and timing counts
// for the output path configuration bank; definitions only
`ifndef AOP_REGS_SVH
`define AOP_REGS_SVH

// spi frame layout
`define AOP_FRAME_BITS 5'd24
`define AOP_ADDR_BITS 5'd8
`define AOP_SYNC_STAGES 2

// base bank registers that gate access to this bank
`define AOP_OFS_BASE_CTRL 8'h00
`define AOP_OFS_BANK_SEL 8'h03
`define AOP_BASE_RD_ON_BIT 1
`define AOP_BANK_SEL_RST 8'h02
`define AOP_BANK_SEL_THIS 8'h02

// output path bank offsets
`define AOP_OFS_FMT_AVG 8'h0d
`define AOP_OFS_SLEW 8'h10
`define AOP_OFS_LANE_SCR 8'h12
`define AOP_OFS_A_PAT_CTRL 8'h13
`define AOP_OFS_A_PAT_ZERO_LO 8'h14
`define AOP_OFS_A_PAT_SHARED 8'h15
`define AOP_OFS_A_PAT_ONE_HI 8'h16
`define AOP_OFS_B_PAT_CTRL 8'h18
`define AOP_OFS_B_PAT_ZERO_LO 8'h19
`define AOP_OFS_B_PAT_SHARED 8'h1a
`define AOP_OFS_B_PAT_ONE_HI 8'h1b
`define AOP_OFS_GAIN_CAL 8'h33
`define AOP_OFS_COMPANION 8'hc5

// reset values
`define AOP_FMT_AVG_RST 16'h2002
`define AOP_LANE_SCR_RST 16'h0002
`define AOP_ZERO_RST 16'h0000

// field positions
`define AOP_FMT_BIT 13
`define AOP_TRIM_HI 9
`define AOP_TRIM_LO 8
`define AOP_GCAL1_BIT 7
`define AOP_AVG_ON_BIT 6
`define AOP_DEPTH_HI 5
`define AOP_DEPTH_LO 2
`define AOP_FAST_SLEW_BIT 0
`define AOP_COMPANION_BIT 13
`define AOP_SCR_BIT 3
`define AOP_LANE_HI 2
`define AOP_LANE_LO 0
`define AOP_LANE_SINGLE_BIT 2
`define AOP_LANE_WIDE_BIT 1
`define AOP_INC_HI 7
`define AOP_INC_LO 4
`define AOP_PSEL_HI 3
`define AOP_PSEL_LO 2
`define AOP_PON_BIT 1
`define AOP_GCAL3_BIT 13
`define AOP_GCAL2_BIT 6

// averaging and scrambler
`define AOP_DEPTH_MAX 4'd3
`define AOP_PRBS_SEED 15'h7fff
`define AOP_NARROW_MASK 24'h0fffff

`endif

// ---- logic/aop_pkg.sv ----
// shared types for the output path configuration block
package aop_pkg;
    // per-channel test pattern choice, in field code order
    typedef enum logic [1:0] {
        AOP_PAT_ZERO,
        AOP_PAT_ZERO_TOO,
        AOP_PAT_RAMP,
        AOP_PAT_ALT
    } aop_pat_sel_t;
endpackage : aop_pkg

// ---- logic/aop_pattern_gen.sv ----
// per-channel digital test pattern generator
// assumes sample_en is a one-cycle pulse on clk, one per output sample
`timescale 1ns/100ps
`include "aop_regs.svh"

module aop_pattern_gen import aop_pkg::*; #(
    parameter int WORD_W = 24
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sample_en,
    input wire logic pattern_on,
    input wire aop_pat_sel_t pattern_sel,
    input wire logic [3:0] ramp_inc,
    input wire logic [WORD_W-1:0] pattern_zero,
    input wire logic [WORD_W-1:0] pattern_one,
    input wire logic wide_word,
    output logic [WORD_W-1:0] pattern_word
);
    if (WORD_W != 24) begin : g_width_check
        $error("pattern words are 24 bits");
    end

    logic [WORD_W-1:0] ramp;
    logic alt_phase;
    logic [WORD_W-1:0] ramp_mask;
    logic [WORD_W-1:0] next_ramp;

    assign ramp_mask = wide_word ? {WORD_W{1'b1}} : `AOP_NARROW_MASK;
    // [RQ9] [RQ18] step of inc plus one, wrapped to word width
    assign next_ramp = (ramp + WORD_W'({ramp_inc} + 5'd1)) & ramp_mask;

    // [RQ18] ramp restarts whenever the pattern is off
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ramp <= '0;
        end else if (!pattern_on) begin
            ramp <= '0;
        end else if (sample_en) begin
            ramp <= next_ramp;
        end
    end

    // alternate phase also restarts while the pattern is off
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            alt_phase <= 1'b0;
        end else if (!pattern_on) begin
            alt_phase <= 1'b0;
        end else if (sample_en) begin
            alt_phase <= ~alt_phase;
        end
    end

    // [RQ10] pattern selection, codes 0 and 1 both fixed zero
    always_comb begin
        unique case (pattern_sel)
            AOP_PAT_ZERO, AOP_PAT_ZERO_TOO: pattern_word = pattern_zero;
            AOP_PAT_RAMP: pattern_word = ramp;
            AOP_PAT_ALT: pattern_word = alt_phase ? pattern_one : pattern_zero;
        endcase
    end

    chk_ramp_step: assert property (@(posedge clk) disable iff (!rst_b) // [RQ9]
        (pattern_on && $past(pattern_on) && $past(sample_en))
        |-> ramp == (($past(ramp) + WORD_W'({$past(ramp_inc)} + 5'd1)) & $past(ramp_mask)))
        else $error("ramp did not advance by increment plus one");

    chk_ramp_restart: assert property (@(posedge clk) disable iff (!rst_b) // [RQ18]
        $rose(pattern_on) |-> ramp == '0)
        else $error("ramp did not restart at zero");

    chk_alt_swap: assert property (@(posedge clk) disable iff (!rst_b) // [RQ10]
        (pattern_on && sample_en && pattern_sel == AOP_PAT_ALT && !alt_phase)
        ##1 (pattern_on && pattern_sel == AOP_PAT_ALT) |-> pattern_word == pattern_one)
        else $error("alternate pattern did not swap to pattern one");
endmodule : aop_pattern_gen

// ---- logic/aop_output_path.sv ----
// output path configuration bank: spi register access, averaging,
// coding, scrambling, test patterns and lane selection
// assumes spi pins are asynchronous to clk; sample inputs are on clk
//
// Function
// [RQ1] bit 13 picks straight binary at 0, two's complement at 1; resets 1.
// [RQ2] bit 6 turns sample averaging on; resets off.
// [RQ3] depth code 0..3 averages 2, 4, 8 or 16 samples.
// [RQ4] three gain calibration enables, each global for all channels.
// [RQ5] host should set latency trim to binary 11 on the fastest part.
// [RQ6] slew bit 0 picks fast slew, paired with a companion enable.
// [RQ7] scramble bit XORs every result bit with the prbs bit.
// [RQ8] lane code picks own or shared lane and 20 or 24 bits.
// [RQ9] ramp advances by increment field plus one every sample.
// [RQ10] mode 0,1 fixed zero; 2 ramp; 3 alternates zero and one.
// [RQ11] pattern enable swaps the result for the channel pattern.
// [RQ12] pattern zero: low 16 bits own register, top 8 in shared.
// [RQ13] pattern one: low 8 bits in shared, top 16 in next register.
// [RQ14] channel b has identical independent pattern registers from 18h.
// [RQ15] host keeps reserved fields at reset values on writes.
// [RQ16] host selects bank code 2 in the base bank first.
// [RQ17] each access is a 24-bit frame: 8 address bits, 16 data.
// [RQ18] ramp wraps at word width and restarts when re-enabled.
`timescale 1ns/100ps
`include "aop_regs.svh"

module aop_output_path import aop_pkg::*; #(
    parameter int RES_W = 18,
    parameter int WORD_W = 24
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cs_b,
    input wire logic sclk,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe_b,
    input wire logic sample_valid,
    input wire logic [RES_W-1:0] chan_a_result,
    input wire logic [RES_W-1:0] chan_b_result,
    output logic out_valid,
    output logic [WORD_W-1:0] lane_a_out,
    output logic [WORD_W-1:0] lane_b_out,
    output logic single_lane,
    output logic wide_word,
    output logic [1:0] latency_trim,
    output logic gain_cal_on_first,
    output logic gain_cal_on_second,
    output logic gain_cal_on_third,
    output logic fast_slew_sel,
    output logic fast_slew_companion_on
);
    if (RES_W != 18 || WORD_W != 24) begin : g_size_check
        $error("path sized for 18-bit results, 24-bit words");
    end

    localparam int ACC_W = RES_W + 5;

    // registers
    logic [15:0] format_average_ctrl, slew_ctrl, lane_scramble_ctrl, gain_cal_enables;
    logic [15:0] pat_ctrl [2];
    logic [15:0] pat_zero_low [2];
    logic [15:0] pat_shared [2];
    logic [15:0] pat_one_high [2];
    logic [15:0] companion_reg;
    logic [7:0] bank_sel;
    logic read_on;

    // spi pin synchronisers, two stages before any logic
    logic [`AOP_SYNC_STAGES-1:0] cs_sync, sclk_sync, sdi_sync;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cs_sync <= '1;
            sclk_sync <= '0;
            sdi_sync <= '0;
        end else begin
            cs_sync <= {cs_sync[0], cs_b};
            sclk_sync <= {sclk_sync[0], sclk};
            sdi_sync <= {sdi_sync[0], sdi};
        end
    end

    logic sclk_prev;
    logic sclk_rise, sclk_fall, frame_on;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) sclk_prev <= 1'b0;
        else sclk_prev <= sclk_sync[1];
    end
    assign frame_on = !cs_sync[1];
    assign sclk_rise = frame_on && sclk_sync[1] && !sclk_prev;
    assign sclk_fall = frame_on && !sclk_sync[1] && sclk_prev;

    // [RQ17] 24-bit frame: address byte then 16 data bits, msb first
    logic [4:0] bit_cnt;
    logic [23:0] shift_in;
    logic [23:0] next_shift_in;
    logic frame_done;
    assign next_shift_in = {shift_in[22:0], sdi_sync[1]};
    assign frame_done = sclk_rise && bit_cnt == `AOP_FRAME_BITS - 5'd1;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bit_cnt <= '0;
            shift_in <= '0;
        end else if (!frame_on) begin
            bit_cnt <= '0;
        end else if (sclk_rise) begin
            shift_in <= next_shift_in;
            bit_cnt <= frame_done ? 5'd0 : bit_cnt + 5'd1;
        end
    end

    logic [7:0] wr_addr;
    logic [15:0] wr_data;
    logic bank_hit, wr_en;
    assign wr_addr = next_shift_in[23:16];
    assign wr_data = next_shift_in[15:0];
    assign bank_hit = bank_sel == `AOP_BANK_SEL_THIS;
    // base control word is always writable so reads can be switched off
    assign wr_en = frame_done && (!read_on || wr_addr == `AOP_OFS_BASE_CTRL);

    // base bank gate registers
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            read_on <= 1'b0;
            bank_sel <= `AOP_BANK_SEL_RST;
        end else if (wr_en && wr_addr == `AOP_OFS_BASE_CTRL) begin
            read_on <= wr_data[`AOP_BASE_RD_ON_BIT];
        end else if (wr_en && wr_addr == `AOP_OFS_BANK_SEL) begin
            bank_sel <= wr_data[7:0];
        end
    end

    // [RQ12] [RQ13] [RQ14] register writes, both channels alike
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            format_average_ctrl <= `AOP_FMT_AVG_RST;
            slew_ctrl <= `AOP_ZERO_RST;
            lane_scramble_ctrl <= `AOP_LANE_SCR_RST;
            gain_cal_enables <= `AOP_ZERO_RST;
            companion_reg <= `AOP_ZERO_RST;
            pat_ctrl <= '{default: `AOP_ZERO_RST};
            pat_zero_low <= '{default: `AOP_ZERO_RST};
            pat_shared <= '{default: `AOP_ZERO_RST};
            pat_one_high <= '{default: `AOP_ZERO_RST};
        end else if (wr_en && bank_hit) begin
            case (wr_addr)
                `AOP_OFS_FMT_AVG: format_average_ctrl <= wr_data;
                `AOP_OFS_SLEW: slew_ctrl <= wr_data;
                `AOP_OFS_LANE_SCR: lane_scramble_ctrl <= wr_data;
                `AOP_OFS_GAIN_CAL: gain_cal_enables <= wr_data;
                `AOP_OFS_COMPANION: companion_reg <= wr_data;
                `AOP_OFS_A_PAT_CTRL: pat_ctrl[0] <= wr_data;
                `AOP_OFS_A_PAT_ZERO_LO: pat_zero_low[0] <= wr_data;
                `AOP_OFS_A_PAT_SHARED: pat_shared[0] <= wr_data;
                `AOP_OFS_A_PAT_ONE_HI: pat_one_high[0] <= wr_data;
                `AOP_OFS_B_PAT_CTRL: pat_ctrl[1] <= wr_data;
                `AOP_OFS_B_PAT_ZERO_LO: pat_zero_low[1] <= wr_data;
                `AOP_OFS_B_PAT_SHARED: pat_shared[1] <= wr_data;
                `AOP_OFS_B_PAT_ONE_HI: pat_one_high[1] <= wr_data;
                default: ;
            endcase
        end
    end

    // readback word; unmapped offsets and other banks read zero
    function automatic logic [15:0] read_word(input logic [7:0] a);
        logic [15:0] w;
        w = '0;
        case (a)
            `AOP_OFS_FMT_AVG: w = format_average_ctrl;
            `AOP_OFS_SLEW: w = slew_ctrl;
            `AOP_OFS_LANE_SCR: w = lane_scramble_ctrl;
            `AOP_OFS_GAIN_CAL: w = gain_cal_enables;
            `AOP_OFS_COMPANION: w = companion_reg;
            `AOP_OFS_A_PAT_CTRL: w = pat_ctrl[0];
            `AOP_OFS_A_PAT_ZERO_LO: w = pat_zero_low[0];
            `AOP_OFS_A_PAT_SHARED: w = pat_shared[0];
            `AOP_OFS_A_PAT_ONE_HI: w = pat_one_high[0];
            `AOP_OFS_B_PAT_CTRL: w = pat_ctrl[1];
            `AOP_OFS_B_PAT_ZERO_LO: w = pat_zero_low[1];
            `AOP_OFS_B_PAT_SHARED: w = pat_shared[1];
            `AOP_OFS_B_PAT_ONE_HI: w = pat_one_high[1];
            default: w = '0;
        endcase
        return w;
    endfunction : read_word

    // read data loads after the address byte and leaves on falling sclk
    logic [15:0] shift_out;
    logic addr_done;
    assign addr_done = sclk_rise && bit_cnt == `AOP_ADDR_BITS - 5'd1;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            shift_out <= '0;
            sdo <= 1'b0;
        end else if (addr_done) begin
            shift_out <= bank_hit ? read_word(next_shift_in[7:0]) : 16'h0000;
        end else if (sclk_fall && bit_cnt >= `AOP_ADDR_BITS) begin
            sdo <= shift_out[15];
            shift_out <= {shift_out[14:0], 1'b0};
        end
    end
    assign sdo_oe_b = !(frame_on && read_on);

    // control fields steering the path
    logic fmt_twos, avg_on, scr_on;
    logic [3:0] depth;
    assign fmt_twos = format_average_ctrl[`AOP_FMT_BIT];
    assign avg_on = format_average_ctrl[`AOP_AVG_ON_BIT];
    assign depth = format_average_ctrl[`AOP_DEPTH_HI:`AOP_DEPTH_LO];
    assign scr_on = lane_scramble_ctrl[`AOP_SCR_BIT];
    // [RQ8] lane code bit 2 shares lane a, bit 1 widens to 24 bits
    assign single_lane = lane_scramble_ctrl[`AOP_LANE_SINGLE_BIT];
    assign wide_word = lane_scramble_ctrl[`AOP_LANE_WIDE_BIT];
    assign latency_trim = format_average_ctrl[`AOP_TRIM_HI:`AOP_TRIM_LO];
    // [RQ4] gain calibration enables drive the calibration engine directly
    assign gain_cal_on_first = format_average_ctrl[`AOP_GCAL1_BIT];
    assign gain_cal_on_second = gain_cal_enables[`AOP_GCAL2_BIT];
    assign gain_cal_on_third = gain_cal_enables[`AOP_GCAL3_BIT];
    // [RQ6] fast slew select with its companion enable
    assign fast_slew_sel = slew_ctrl[`AOP_FAST_SLEW_BIT];
    assign fast_slew_companion_on = companion_reg[`AOP_COMPANION_BIT];

    // [RQ2] [RQ3] averaging over 2 to the (depth+1) samples
    logic [3:0] shift_n;
    logic [4:0] avg_cnt, avg_last;
    logic signed [ACC_W-1:0] acc [2];
    logic [RES_W-1:0] avg_out [2];
    logic avg_valid;
    logic [RES_W-1:0] raw [2];
    assign raw[0] = chan_a_result;
    assign raw[1] = chan_b_result;
    // depth codes above the table clamp to the deepest setting
    assign shift_n = ((depth > `AOP_DEPTH_MAX) ? `AOP_DEPTH_MAX : depth) + 4'd1;
    assign avg_last = 5'((5'd1 << shift_n) - 5'd1);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            avg_cnt <= '0;
            acc <= '{default: '0};
            avg_out <= '{default: '0};
            avg_valid <= 1'b0;
        end else begin
            avg_valid <= 1'b0;
            if (!avg_on) begin
                avg_cnt <= '0;
                acc <= '{default: '0};
                if (sample_valid) begin
                    avg_out <= raw;
                    avg_valid <= 1'b1;
                end
            end else if (sample_valid) begin
                for (int c = 0; c < 2; c++) begin
                    if (avg_cnt == avg_last) begin
                        avg_out[c] <= RES_W'((acc[c] + ACC_W'(signed'(raw[c]))) >>> shift_n);
                        acc[c] <= '0;
                    end else begin
                        acc[c] <= acc[c] + ACC_W'(signed'(raw[c]));
                    end
                end
                avg_valid <= avg_cnt == avg_last;
                avg_cnt <= (avg_cnt == avg_last) ? 5'd0 : avg_cnt + 5'd1;
            end
        end
    end

    // scrambler sequence, one step per output sample
    logic [14:0] prbs;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) prbs <= `AOP_PRBS_SEED;
        else if (avg_valid) prbs <= {prbs[13:0], prbs[14] ^ prbs[13]};
    end

    // per-channel patterns share one generator design
    logic [WORD_W-1:0] pat_word [2];
    logic [WORD_W-1:0] next_word [2];
    for (genvar c = 0; c < 2; c++) begin : g_chan
        logic [RES_W-1:0] coded;
        logic [WORD_W-1:0] result_word;
        // [RQ1] straight binary flips the sign bit of the twos value
        assign coded = (fmt_twos ? avg_out[c] : {~avg_out[c][RES_W-1], avg_out[c][RES_W-2:0]})
            ^ {RES_W{scr_on & prbs[14]}}; // [RQ7] all 18 result bits XOR with prbs bit, padding untouched
        // result sits msb-aligned in the 20 or 24 bit word
        assign result_word = wide_word ? {coded, 6'h00} : {4'h0, coded, 2'h0};
        // [RQ11] pattern enable overrides the conversion result
        assign next_word[c] = pat_ctrl[c][`AOP_PON_BIT] ? pat_word[c] : result_word;
        aop_pattern_gen #(.WORD_W(WORD_W)) u_pat (
            .clk(clk),
            .rst_b(rst_b),
            .sample_en(avg_valid),
            .pattern_on(pat_ctrl[c][`AOP_PON_BIT]),
            .pattern_sel(aop_pat_sel_t'(pat_ctrl[c][`AOP_PSEL_HI:`AOP_PSEL_LO])),
            .ramp_inc(pat_ctrl[c][`AOP_INC_HI:`AOP_INC_LO]),
            .pattern_zero({pat_shared[c][7:0], pat_zero_low[c]}),
            .pattern_one({pat_one_high[c], pat_shared[c][15:8]}),
            .wide_word(wide_word),
            .pattern_word(pat_word[c])
        );
    end

    // output words register on each finished sample
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lane_a_out <= '0;
            lane_b_out <= '0;
            out_valid <= 1'b0;
        end else begin
            out_valid <= avg_valid;
            if (avg_valid) begin
                lane_a_out <= next_word[0];
                lane_b_out <= next_word[1];
            end
        end
    end

    chk_write_lands: assert property (@(posedge clk) disable iff (!rst_b) // [RQ17]
        (wr_en && bank_hit && wr_addr == `AOP_OFS_LANE_SCR) |=> lane_scramble_ctrl == $past(wr_data))
        else $error("lane register did not take the written word");

    chk_avg_count: assert property (@(posedge clk) disable iff (!rst_b) // [RQ3]
        (avg_on && depth == 4'd1 && sample_valid)
        |=> avg_valid == $past(avg_cnt == 5'd3))
        else $error("averaging of four samples did not complete");

    chk_avg_pass: assert property (@(posedge clk) disable iff (!rst_b) // [RQ2]
        (!avg_on && sample_valid) |=> avg_valid && avg_out[0] == $past(chan_a_result))
        else $error("result not passed through with averaging off");

    chk_pat_override: assert property (@(posedge clk) disable iff (!rst_b) // [RQ11]
        (avg_valid && pat_ctrl[1][`AOP_PON_BIT]) |=> out_valid && lane_b_out == $past(pat_word[1]))
        else $error("channel b pattern did not replace the result");

    chk_coding_sel: assert property (@(posedge clk) disable iff (!rst_b) // [RQ1]
        (avg_valid && !pat_ctrl[0][`AOP_PON_BIT] && wide_word && !scr_on && !fmt_twos)
        |=> lane_a_out[WORD_W-1] == !$past(avg_out[0][RES_W-1]))
        else $error("straight binary did not flip the sign bit");

    chk_scramble: assert property (@(posedge clk) disable iff (!rst_b) // [RQ7]
        (avg_valid && !pat_ctrl[0][`AOP_PON_BIT] && wide_word && fmt_twos && scr_on)
        |=> lane_a_out[WORD_W-1:WORD_W-RES_W] == ($past(avg_out[0]) ^ {RES_W{$past(prbs[14])}}))
        else $error("scrambled word does not match prbs bit");
endmodule : aop_output_path

// ---- verif/aop_spi_host.sv ----
// spi host model for the configuration port: mode 0, msb first
// assumes the device samples sdi on sclk rise and shifts sdo on sclk fall
`timescale 1ns/100ps

module aop_spi_host (
    input wire logic clk,
    output logic cs_b,
    output logic sclk,
    output logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe_b
);
    // four clk per sclk phase keeps clear of the two-stage pin sync
    localparam int HALF = 4;

    // idle pins: chip deselected, sclk parked low
    initial begin
        cs_b = 1'b1;
        sclk = 1'b0;
        sdi = 1'b0;
    end

    // sdi is not held between frames, so stale values cannot pass
    always @(posedge clk) begin
        if (cs_b) begin
            sdi <= ~sdi;
        end
    end

    // address then data frame
    // undriven sdo reads as unknown so an idle output never matches
    task automatic xfer(input logic [23:0] word, input int nbits, output logic [15:0] rd);
        rd = 16'h0000;
        @(negedge clk);
        cs_b = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            sdi = word[23-i];
            repeat (HALF) @(negedge clk);
            sclk = 1'b1;
            if (i >= 8) begin
                rd = {rd[14:0], sdo_oe_b ? 1'bx : sdo};
            end
            repeat (HALF) @(negedge clk);
            sclk = 1'b0;
        end
        repeat (HALF) @(negedge clk);
        cs_b = 1'b1;
    endtask : xfer
endmodule : aop_spi_host

// ---- verif/aop_output_path_test.sv ----
// self-checking bench for the output path configuration bank
// assumes the spi host model drives the configuration pins
`timescale 1ns/100ps

module aop_output_path_test;
    logic clk = 1'b0;
    logic rst_b, sample_valid, cs_b, sclk, sdi, sdo, sdo_oe_b, out_valid;
    logic single_lane, wide_word, gcal1, gcal2, gcal3, fslew, fcomp;
    logic [1:0] latency_trim;
    logic [3:0] inc;
    logic [15:0] d;
    logic [15:0] lfsr_state = 16'h0016;
    logic [17:0] ra, rb, r;
    logic [23:0] lane_a_out, lane_b_out, seen_a, seen_b, got, z, o, p;
    logic [7:0] reg_list [13] = '{8'h0d, 8'h10, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16,
        8'h18, 8'h19, 8'h1a, 8'h1b, 8'h33, 8'h40};
    logic [2:0] codes [4] = '{3'h0, 3'h2, 3'h5, 3'h7};
    int bad_count = 0;
    int samples_checked = 0;

    aop_output_path i_aop_output_path (.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .sclk(sclk),
        .sdi(sdi), .sdo(sdo), .sdo_oe_b(sdo_oe_b), .sample_valid(sample_valid),
        .chan_a_result(ra), .chan_b_result(rb), .out_valid(out_valid),
        .lane_a_out(lane_a_out), .lane_b_out(lane_b_out), .single_lane(single_lane),
        .wide_word(wide_word), .latency_trim(latency_trim), .gain_cal_on_first(gcal1),
        .gain_cal_on_second(gcal2), .gain_cal_on_third(gcal3), .fast_slew_sel(fslew),
        .fast_slew_companion_on(fcomp));
    aop_spi_host i_aop_spi_host (.clk(clk), .cs_b(cs_b), .sclk(sclk), .sdi(sdi), .sdo(sdo),
        .sdo_oe_b(sdo_oe_b));

    // 20 MHz clock
    always #25 clk = ~clk;

    // fixed-seed lfsr; the low bits are folded from the top for variety
    function automatic logic [17:0] rand18();
        lfsr_state = {lfsr_state[14:0],
            lfsr_state[15] ^ lfsr_state[13] ^ lfsr_state[12] ^ lfsr_state[10]};
        return {lfsr_state, lfsr_state[15:14] ^ lfsr_state[1:0]};
    endfunction : rand18

    // msb-aligned word; straight binary flips the sign bit
    function automatic logic [23:0] exp_word(input logic [17:0] v, input logic fmt,
        input logic wide);
        logic [17:0] c;
        c = {v[17] ^ ~fmt, v[16:0]};
        return wide ? {c, 6'h00} : {4'h0, c, 2'h0};
    endfunction : exp_word

    function automatic logic [23:0] status();
        return {14'h0000, single_lane, wide_word, latency_trim, gcal1, gcal2, gcal3,
            fslew, fcomp, sdo_oe_b};
    endfunction : status

    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        logic [15:0] unused;
        i_aop_spi_host.xfer({a, v}, 24, unused);
    endtask : wr

    task automatic rd_reg(input logic [7:0] a, output logic [15:0] v);
        i_aop_spi_host.xfer({a, 16'h0000}, 24, v);
    endtask : rd_reg

    // one sample pulse, then a bounded look for the output strobe
    task automatic push(input logic [17:0] a, input logic [17:0] b, output logic [23:0] n);
        n = 24'h000000;
        @(negedge clk);
        ra = a;
        rb = b;
        sample_valid = 1'b1;
        @(negedge clk);
        sample_valid = 1'b0;
        repeat (4) begin
            @(negedge clk);
            if (out_valid === 1'b1) begin
                n++;
                seen_a = lane_a_out;
                seen_b = lane_b_out;
            end
        end
    endtask : push

    task automatic report_and_stop();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop

    // hang guard
    initial begin
        repeat (90000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end

    initial begin
        rst_b = 1'b0;
        sample_valid = 1'b0;
        ra = 18'h00000;
        rb = 18'h00000;
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        check("reset status", status(), 24'h000101);
        // read mode: writes other than the mode word are dropped
        wr(8'h00, 16'h0002);
        wr(8'h12, 16'h0007);
        foreach (reg_list[i]) begin
            rd_reg(reg_list[i], d);
            check("reset value", {8'h00, d}, reg_list[i] == 8'h0d ? 24'h002002 :
                reg_list[i] == 8'h12 ? 24'h000002 : 24'h000000);
        end
        wr(8'h00, 16'h0000);
        // reserved low bits of 0d kept at 2, latency trim 11
        wr(8'h0d, 16'h2382);
        wr(8'h33, 16'h2040);
        wr(8'h10, 16'h0001);
        wr(8'hc5, 16'h2000);
        check("control outputs", status(), 24'h0001ff);
        foreach (codes[i]) begin
            wr(8'h12, {13'h0000, codes[i]});
            check("lane code", {22'h0, single_lane, wide_word}, {22'h0, codes[i][2:1]});
        end
        wr(8'h03, 16'h0000);
        wr(8'h12, 16'h0002);
        check("other bank", {22'h0, single_lane, wide_word}, 24'h000003);
        wr(8'h03, 16'h0002);
        i_aop_spi_host.xfer({8'h12, 16'h0002}, 12, d);
        check("aborted frame", {22'h0, single_lane, wide_word}, 24'h000003);
        for (int k = 0; k < 3; k++) begin
            wr(8'h0d, k == 1 ? 16'h0002 : 16'h2002);
            wr(8'h12, k == 2 ? 16'h0000 : 16'h0002);
            push(rand18(), rand18(), got);
            check("result a", seen_a, exp_word(ra, k != 1, k != 2));
            check("result b", seen_b, exp_word(rb, k != 1, k != 2));
        end
        // every result bit flips together with the prbs bit
        wr(8'h12, 16'h000a);
        p = 24'h000000;
        repeat (16) begin
            push(rand18(), rand18(), got);
            z = seen_a ^ {ra, 6'h00};
            check("scramble mask", {23'h0, z === 24'h0 || z === 24'hffffc0}, 24'h1);
            p = p | z;
        end
        check("scramble applied", p, 24'hffffc0);
        wr(8'h12, 16'h0002);
        for (int dp = 0; dp < 4; dp++) begin
            wr(8'h0d, 16'h2042 | {10'h000, dp[3:0], 2'h0});
            r = rand18();
            for (int i = 0; i < (2 << dp); i++) begin
                push(r, ~r, got);
                check("average strobe", got, {23'h0, i == (2 << dp) - 1});
            end
            check("average a", seen_a, {r, 6'h00});
            check("average b", seen_b, {~r, 6'h00});
        end
        wr(8'h0d, 16'h2002);
        z = {rand18(), 6'h15};
        o = {6'h2a, rand18()};
        wr(8'h14, z[15:0]);
        wr(8'h15, {o[7:0], z[23:16]});
        wr(8'h16, o[23:8]);
        wr(8'h19, o[15:0]);
        wr(8'h1a, {z[7:0], o[23:16]});
        wr(8'h1b, z[23:8]);
        for (int s = 0; s < 2; s++) begin
            wr(8'h13, s == 1 ? 16'h0006 : 16'h0002);
            push(rand18(), rand18(), got);
            check("fixed pattern a", seen_a, z);
            check("result on b", seen_b, exp_word(rb, 1'b1, 1'b1));
        end
        wr(8'h13, 16'h0000);
        wr(8'h13, 16'h000e);
        wr(8'h18, 16'h000e);
        for (int i = 0; i < 3; i++) begin
            push(rand18(), rand18(), got);
            check("alternate a", seen_a, i == 1 ? o : z);
            check("alternate b", seen_b, i == 1 ? z : o);
        end
        r = rand18();
        inc = r[3:0];
        for (int n = 0; n < 2; n++) begin
            wr(8'h13, 16'h0000);
            wr(8'h13, {8'h00, inc, 4'ha});
            push(ra, rb, got);
            check("ramp restart", seen_a, 24'h000000);
            push(ra, rb, got);
            check("ramp step", seen_a, {20'h00000, inc} + 24'h000001);
        end
        report_and_stop();
    end
endmodule : aop_output_path_test
